// ---- logic/odl_pkg.sv ----
/*
 Shared constants, types and register layout of the one-wire debug link controller.
 Assumes a single 100 MHz core clock; the link line is sampled synchronously to it.
*/
`default_nettype none
package odl_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned CLK_PERIOD_NS = 10;

	// start-up window: 65536 link cycles, 16.4 ms at a 4 MHz link clock
	localparam int unsigned STARTUP_TIMEOUT_DEF = 65536;
	localparam int unsigned STARTUP_TIMEOUT_US_AT_4MHZ = 16400;
	localparam int unsigned STARTUP_CNT_W = 17;

	// output driver hold-off after every system reset
	localparam int unsigned GPIO_GUARD_US = 8800;
	localparam int unsigned GPIO_GUARD_CYCLES_DEF = GPIO_GUARD_US * (CLK_HZ / 1_000_000);
	localparam int unsigned GPIO_CNT_W = 20;

	// baud measurement: 16-bit total over 8 bits of the sync character
	localparam int unsigned BAUD_W = 16;
	localparam int unsigned SYNC_SHIFT = 3;
	localparam int unsigned BIT_W = BAUD_W - SYNC_SHIFT;
	localparam logic [2:0] SYNC_FALLS_LAST = 3'h3;
	localparam logic [BIT_W-1:0] MIN_BIT_CYCLES = 13'h0008;
	localparam logic [BIT_W-1:0] BIT_MAX = 13'h1fff;
	localparam logic [BIT_W-1:0] BIT_ONE = 13'h0001;
	localparam logic [7:0] SYNC_CHAR = 8'h55;

	// frame: start, 8 data, even parity, 2 stop
	localparam logic [3:0] FRAME_LAST = 4'hb;
	localparam logic [3:0] DATA_FIRST = 4'h1;
	localparam logic [3:0] PARITY_POS = 4'h9;
	localparam logic [3:0] STOP_FIRST = 4'ha;
	localparam logic [4:0] BREAK_BITS = 5'h0c;
	localparam int unsigned LOW_CNT_W = 18;
	localparam logic [3:0] IDLE_SAT = 4'hf;

	localparam logic FUSE_PIN_LINK = 1'b1;

	// error signature codes
	localparam logic [2:0] ERR_NONE = 3'h0;
	localparam logic [2:0] ERR_PARITY = 3'h1;
	localparam logic [2:0] ERR_FRAME = 3'h2;
	localparam logic [2:0] ERR_CONTENTION = 3'h3;
	localparam logic [2:0] ERR_ACCESS_TIMEOUT = 3'h4;

	// register map (byte addresses)
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] ADDR_CTRL_A = 8'h00;
	localparam logic [7:0] ADDR_CTRL_B = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_BAUD = 8'h0c;
	localparam int unsigned CA_GUARD_LSB = 0;
	localparam int unsigned CA_CLKSEL_LSB = 4;
	localparam int unsigned CB_DISABLE_BIT = 0;
	localparam int unsigned ST_STATE_LSB = 0;
	localparam int unsigned ST_SIG_LSB = 8;
	localparam int unsigned ST_OWNED_BIT = 12;
	localparam int unsigned ST_CLKREQ_BIT = 13;
	localparam int unsigned ST_NEEDSYNC_BIT = 14;

	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef struct packed {
		logic [1:0] clk_sel;
		logic [2:0] guard;
	} odl_ctrl_t;

	localparam logic [1:0] CLKSEL_DEFAULT = 2'h3;
	localparam logic [2:0] GUARD_RESET = 3'h1;
	localparam odl_ctrl_t CTRL_RESET = '{clk_sel: CLKSEL_DEFAULT, guard: GUARD_RESET};

	typedef enum logic [3:0] {
		ST_OFF,
		ST_DRIVE_LOW,
		ST_WAIT_START,
		ST_SYNC,
		ST_IDLE,
		ST_RX,
		ST_TX,
		ST_ERROR
	} odl_state_t;
endpackage
`default_nettype wire

// ---- logic/odl_sync_meas.sv ----
/*
 Sync character timer: measures the 0x55 pattern from its start edge to its fifth falling edge.
 Assumes start is a one-cycle pulse on the start-bit falling edge and line_in is synchronous.
*/
`default_nettype none
module odl_sync_meas
	import odl_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic start,
	input wire logic abort,
	input wire logic line_in,
	output logic busy,
	output logic done,
	output logic ok,
	output logic [BIT_W-1:0] bit_len
);
	logic [BAUD_W:0] cnt;
	logic [2:0] falls;
	logic line_prev;
	logic fall;
	logic too_short;

	assign fall = line_prev & ~line_in;
	assign too_short = cnt[BAUD_W-1:SYNC_SHIFT] < MIN_BIT_CYCLES;

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			line_prev <= 1'b1;
		else if (ce)
			line_prev <= line_in;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			busy <= 1'b0;
			done <= 1'b0;
			ok <= 1'b0;
			cnt <= '0;
			falls <= '0;
			bit_len <= BIT_MAX;
		end
		else if (ce)
		begin
			done <= 1'b0;
			if (abort)
			begin
				busy <= 1'b0;
				bit_len <= BIT_MAX;
			end
			else if (start)
			begin
				busy <= 1'b1;
				cnt <= (BAUD_W+1)'(1);
				falls <= '0;
			end
			else if (busy)
			begin
				cnt <= cnt + (BAUD_W+1)'(1);
				if (cnt[BAUD_W])
				begin
					busy <= 1'b0;
					done <= 1'b1;
					ok <= 1'b0;
				end
				else if (fall)
				begin
					falls <= falls + 3'h1;
					if (falls == SYNC_FALLS_LAST)
					begin
						busy <= 1'b0;
						done <= 1'b1;
						ok <= !too_short;
						if (!too_short)
							bit_len <= cnt[BAUD_W-1:SYNC_SHIFT];
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- logic/odl_link_ctrl.sv ----
/*
 One-wire debug link control: pin takeover, enable and start-up checks, break and error
 handling, guard time, byte framing, and an AXI4-Lite register slave.
 Assumes hv_pulse is already a synchronised one-cycle pulse and the fuse is static.
*/
// Implementation choices: register access over AXI4-Lite and the address map.
`default_nettype none
module odl_link_ctrl
	import odl_pkg::*;
#(
	parameter int unsigned STARTUP_TIMEOUT = STARTUP_TIMEOUT_DEF,
	parameter int unsigned GPIO_GUARD_CYCLES = GPIO_GUARD_CYCLES_DEF
)
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic line_in,
	output logic line_out,
	output logic line_oe,
	output logic pullup_en,
	input wire logic fuse_reset_pin_config,
	input wire logic hv_pulse,
	input wire logic clk_ready,
	output logic clk_req,
	output logic [1:0] link_clock_select,
	input wire logic sys_reset_evt,
	output logic gpio_oe_allow,
	output logic sys_reset_req,
	input wire logic rx_expect_sync,
	output logic rx_valid,
	output logic [7:0] rx_data,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	input wire logic acc_timeout,
	input wire logic sig_read
);
	odl_state_t state;
	odl_ctrl_t ctrl;
	logic fuse_link, fuse_seen, hv_owned, pin_owned;
	logic line_prev, fall, brk, link_dis, need_sync;
	logic [STARTUP_CNT_W-1:0] start_cnt;
	logic [GPIO_CNT_W-1:0] gpio_cnt;
	logic [LOW_CNT_W-1:0] low_cnt, brk_lim;
	logic [BIT_W-1:0] tick, bit_len;
	logic [3:0] bcnt, idle_bits;
	logic [8:0] rx_sh;
	logic [11:0] tx_sh;
	logic stop_bad, guard_met, frame_end, bit_end;
	logic meas_start, meas_busy, meas_done, meas_ok;
	logic err_par, err_frm, err_cont, err_acc, err_evt;
	logic [2:0] err_code, error_signature;
	logic aw_hold, w_hold, wr_fire, rd_fire;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q, rd_word;
	logic [3:0] wstrb_q;

	function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
		reg_hit = (a == ADDR_CTRL_A) || (a == ADDR_CTRL_B) || (a == ADDR_STATUS) || (a == ADDR_BAUD);
	endfunction

	// fuse caught once after reset release
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fuse_link <= 1'b0;
			fuse_seen <= 1'b0;
		end
		else if (ce && !fuse_seen)
		begin
			fuse_link <= (fuse_reset_pin_config == FUSE_PIN_LINK);
			fuse_seen <= 1'b1;
		end
	end

	// only power-on reset frees the pin
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			hv_owned <= 1'b0;
		else if (ce && hv_pulse)
			hv_owned <= 1'b1;
	end

	assign pin_owned = fuse_link | hv_owned;
	assign pullup_en = pin_owned;

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			gpio_cnt <= GPIO_CNT_W'(GPIO_GUARD_CYCLES);
		else if (ce)
		begin
			if (sys_reset_evt)
				gpio_cnt <= GPIO_CNT_W'(GPIO_GUARD_CYCLES);
			else if (gpio_cnt != '0)
				gpio_cnt <= gpio_cnt - GPIO_CNT_W'(1);
		end
	end
	assign gpio_oe_allow = fuse_seen && !pin_owned && (gpio_cnt == '0);

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			line_prev <= 1'b1;
		else if (ce)
			line_prev <= line_in;
	end
	assign fall = line_prev & ~line_in;

	// break: line held low by the far end for twelve bit times
	assign brk_lim = LOW_CNT_W'(bit_len) * LOW_CNT_W'(BREAK_BITS);
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			low_cnt <= '0;
		else if (ce)
		begin
			if (line_in || line_oe)
				low_cnt <= '0;
			else if (low_cnt <= brk_lim)
				low_cnt <= low_cnt + LOW_CNT_W'(1);
		end
	end
	assign brk = !line_in && !line_oe && (low_cnt == brk_lim) && (state > ST_WAIT_START);

	// AXI4-Lite slave, one write and one read in flight
	assign s_axi_awready = ce && !aw_hold;
	assign s_axi_wready = ce && !w_hold;
	assign s_axi_arready = ce && !s_axi_rvalid;
	assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign link_dis = ce && wr_fire && (awaddr_q == ADDR_CTRL_B) && wstrb_q[0] && wdata_q[CB_DISABLE_BIT];

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= AXI_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			else if (wr_fire)
				aw_hold <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			else if (wr_fire)
				w_hold <= 1'b0;
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= reg_hit(awaddr_q) ? AXI_OKAY : AXI_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_comb
	begin
		rd_word = '0;
		if (s_axi_araddr == ADDR_CTRL_A)
		begin
			rd_word[CA_GUARD_LSB +: 3] = ctrl.guard;
			rd_word[CA_CLKSEL_LSB +: 2] = ctrl.clk_sel;
		end
		else if (s_axi_araddr == ADDR_STATUS)
		begin
			rd_word[ST_STATE_LSB +: 4] = state;
			rd_word[ST_SIG_LSB +: 3] = error_signature;
			rd_word[ST_OWNED_BIT] = pin_owned;
			rd_word[ST_CLKREQ_BIT] = clk_req;
			rd_word[ST_NEEDSYNC_BIT] = need_sync;
		end
		else if (s_axi_araddr == ADDR_BAUD)
			rd_word[BIT_W-1:0] = bit_len;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= AXI_OKAY;
		end
		else if (ce)
		begin
			if (rd_fire)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= reg_hit(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			ctrl <= CTRL_RESET;
		else if (ce)
		begin
			if (link_dis)
				ctrl <= CTRL_RESET;
			else if (brk)
				ctrl.clk_sel <= CLKSEL_DEFAULT;
			else if (wr_fire && (awaddr_q == ADDR_CTRL_A) && wstrb_q[0])
			begin
				ctrl.guard <= wdata_q[CA_GUARD_LSB +: 3];
				ctrl.clk_sel <= wdata_q[CA_CLKSEL_LSB +: 2];
			end
		end
	end
	assign link_clock_select = ctrl.clk_sel;

	// system reset and key clear pulse
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			sys_reset_req <= 1'b0;
		else if (ce)
			sys_reset_req <= link_dis;
	end

	// request held while the link is on
	assign clk_req = (state != ST_OFF);

	// sync owed after enable or break
	assign meas_start = fall && !brk && ((state == ST_WAIT_START) || ((state == ST_IDLE) && (need_sync || rx_expect_sync)));
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			need_sync <= 1'b1;
		else if (ce)
		begin
			if (link_dis || hv_pulse || brk || state == ST_OFF)
				need_sync <= 1'b1;
			else if (meas_done && meas_ok)
				need_sync <= 1'b0;
		end
	end

	odl_sync_meas u_meas (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.ce(ce),
		.start(meas_start),
		.abort(link_dis || hv_pulse || brk),
		.line_in(line_in),
		.busy(meas_busy),
		.done(meas_done),
		.ok(meas_ok),
		.bit_len(bit_len)
	);

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			start_cnt <= '0;
		else if (ce)
			start_cnt <= (state == ST_WAIT_START) ? start_cnt + STARTUP_CNT_W'(1) : '0;
	end

	// bit timing shared by receive, transmit and idle counting
	assign bit_end = (tick == '0);
	assign frame_end = ((state == ST_RX) || (state == ST_TX)) && bit_end && (bcnt == FRAME_LAST);
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tick <= '0;
			bcnt <= '0;
			idle_bits <= '0;
		end
		else if (ce)
		begin
			if (state == ST_IDLE && fall)
			begin
				tick <= bit_len >> 1;
				bcnt <= '0;
			end
			else if (state == ST_IDLE && tx_valid && tx_ready)
			begin
				tick <= bit_len - BIT_ONE;
				bcnt <= '0;
			end
			else if (state == ST_RX || state == ST_TX || state == ST_IDLE)
			begin
				tick <= bit_end ? bit_len - BIT_ONE : tick - BIT_ONE;
				if (bit_end)
					bcnt <= bcnt + 4'h1;
			end
			else
				tick <= bit_len - BIT_ONE;
			// idle bits counted at the current rate
			if (state != ST_IDLE)
				idle_bits <= '0;
			else if (bit_end && idle_bits != IDLE_SAT)
				idle_bits <= idle_bits + 4'h1;
		end
	end

	// reply waits at least guard+1 idle bits
	assign guard_met = idle_bits > {1'b0, ctrl.guard};
	assign tx_ready = (state == ST_IDLE) && guard_met && !fall && !need_sync && !rx_expect_sync;

	// receive shift and checks
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_sh <= '0;
			stop_bad <= 1'b0;
			rx_valid <= 1'b0;
			rx_data <= '0;
		end
		else if (ce)
		begin
			rx_valid <= 1'b0;
			if (state == ST_RX && bit_end)
			begin
				if (bcnt == '0)
					stop_bad <= line_in;
				else if (bcnt <= PARITY_POS)
					rx_sh <= {line_in, rx_sh[8:1]};
				else if (!line_in)
					stop_bad <= 1'b1;
				// byte handed on only with good parity and framing
				if (frame_end && !err_par && !err_frm)
				begin
					rx_valid <= 1'b1;
					rx_data <= rx_sh[7:0];
				end
			end
		end
	end

	// transmit shift: start, data, even parity, two stops
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			tx_sh <= '1;
		else if (ce)
		begin
			if (tx_valid && tx_ready)
				tx_sh <= {2'b11, ^tx_data, tx_data, 1'b0};
			else if (state == ST_TX && bit_end)
				tx_sh <= {1'b1, tx_sh[11:1]};
		end
	end
	assign line_oe = (state == ST_DRIVE_LOW) || (state == ST_TX);
	assign line_out = (state == ST_TX) && tx_sh[0];

	assign err_par = frame_end && (state == ST_RX) && (^rx_sh);
	assign err_frm = frame_end && (state == ST_RX) && (stop_bad || !line_in);
	assign err_cont = (state == ST_TX) && (tick == (bit_len >> 1)) && (line_in != tx_sh[0]);
	assign err_acc = acc_timeout && (state == ST_IDLE || state == ST_RX || state == ST_TX);
	assign err_evt = !brk && (err_par || err_frm || err_cont || err_acc);
	always_comb
	begin
		err_code = ERR_NONE;
		if (err_cont)
			err_code = ERR_CONTENTION;
		else if (err_frm)
			err_code = ERR_FRAME;
		else if (err_par)
			err_code = ERR_PARITY;
		else if (err_acc)
			err_code = ERR_ACCESS_TIMEOUT;
	end

	// new error wins over a read in the same cycle
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			error_signature <= ERR_NONE;
		else if (ce)
		begin
			if (link_dis)
				error_signature <= ERR_NONE;
			else if (err_evt)
				error_signature <= err_code;
			else if (sig_read)
				error_signature <= ERR_NONE;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			state <= ST_OFF;
		else if (ce)
		begin
			if (link_dis || hv_pulse)
				state <= ST_OFF;
			else if (brk)
				state <= ST_IDLE;
			else if (err_evt)
				state <= ST_ERROR;
			else
			begin
				unique case (state)
					ST_OFF: if (pin_owned && fall) state <= ST_DRIVE_LOW;
					ST_DRIVE_LOW: if (clk_ready) state <= ST_WAIT_START;
					ST_WAIT_START:
						if (fall)
							state <= ST_SYNC;
						else if (start_cnt == STARTUP_CNT_W'(STARTUP_TIMEOUT - 1))
							state <= ST_OFF;
					ST_SYNC: if (meas_done) state <= meas_ok ? ST_IDLE : ST_OFF;
					ST_IDLE:
						if (meas_start)
							state <= ST_SYNC;
						else if (fall)
							state <= ST_RX;
						else if (tx_valid && tx_ready)
							state <= ST_TX;
					ST_RX: if (frame_end) state <= ST_IDLE;
					ST_TX: if (frame_end) state <= ST_IDLE;
					ST_ERROR: state <= ST_ERROR;
				endcase
			end
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n || !ce);

	sequence s_enable_edge;
		state == ST_OFF && pin_owned && fall && !hv_pulse && !link_dis;
	endsequence
	sequence s_clock_ready;
		state == ST_DRIVE_LOW && clk_ready && !hv_pulse && !link_dis;
	endsequence

	a_enable_drive: assert property (s_enable_edge |=> line_oe && !line_out && clk_req)
		else $error("line not driven low after enable edge");
	a_release_line: assert property (s_enable_edge ##1 s_clock_ready |=> state == ST_WAIT_START && !line_oe)
		else $error("line not released once clock ready");
	a_startup_window: assert property (state == ST_WAIT_START && !fall && !hv_pulse && !link_dis
		&& start_cnt == STARTUP_CNT_W'(STARTUP_TIMEOUT - 1) |=> state == ST_OFF && !clk_req)
		else $error("start-up window not enforced");
	a_hv_takeover: assert property (hv_pulse |=> pin_owned && state == ST_OFF)
		else $error("high-voltage pulse did not take the pin");
	a_hv_keep_pin: assert property (hv_owned && link_dis |=> pin_owned && !clk_req)
		else $error("pin lost after disable");
	a_gpio_holdoff: assert property (sys_reset_evt |=> !gpio_oe_allow [*8])
		else $error("gpio driver allowed too soon");
	a_bad_sync_off: assert property (state == ST_SYNC && meas_done && !meas_ok && !brk && !hv_pulse |=> state == ST_OFF)
		else $error("bad sync did not disable");
	a_disable_clear: assert property (link_dis |=> sys_reset_req && ctrl == CTRL_RESET && state == ST_OFF
		&& error_signature == ERR_NONE)
		else $error("disable did not reset link");
	a_parity_sig: assert property (err_par && !err_frm && !link_dis && !brk && !hv_pulse
		|=> error_signature == ERR_PARITY && state == ST_ERROR)
		else $error("parity error not recorded");
	a_error_stays: assert property (state == ST_ERROR && !brk && !link_dis && !hv_pulse |=> state == ST_ERROR && !tx_ready)
		else $error("error state left without break");
	a_break_default: assert property (brk && !link_dis && !hv_pulse |=> link_clock_select == CLKSEL_DEFAULT
		&& state == ST_IDLE && need_sync)
		else $error("break did not restore defaults");
	a_guard_before_tx: assert property ($rose(state == ST_TX) |-> $past(guard_met))
		else $error("reply started inside guard time");
	a_sig_hold: assert property (error_signature != ERR_NONE && !sig_read && !link_dis && !err_evt
		|=> $stable(error_signature))
		else $error("signature changed without read");
endmodule
`default_nettype wire

// ---- verif/odl_debugger.sv ----
/*
 debugger model that pulls the one-wire line low.
 assumes the bench resolves the wire with the device driver and a pull-up.
*/
`default_nettype none
module odl_debugger
(
	input wire logic core_clk,
	output logic pull_low
);
	timeunit 1ns;
	timeprecision 1ps;
	initial pull_low = 1'b0;
	task automatic hold(input logic v, input int n);
		if (core_clk !== 1'b1)
			@(posedge core_clk);
		pull_low <= !v;
		repeat (n) @(posedge core_clk);
	endtask
	task automatic frame(input logic [7:0] d, input int bl, input logic bad);
		hold(1'b0, bl);
		for (int i = 0; i < 8; i++)
			hold(d[i], bl);
		hold(^d ^ bad, bl);
		hold(1'b1, 2 * bl);
	endtask
endmodule
`default_nettype wire

// ---- verif/test_one_wire_debug_link_control.sv ----
/*
 bench for the link controller: axi4-lite master, wire resolution, scenarios.
 assumes one 100 MHz clock and a pulled-up line.
*/
`default_nettype none
module test_one_wire_debug_link_control
	import odl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int STO = 200;
	localparam int GG = 20;
	logic core_clk, arst_n, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, line_out, line_oe;
	logic pullup_en, fuse_reset_pin_config, hv_pulse, clk_ready, clk_req, sys_reset_evt, gpio_oe_allow;
	logic sys_reset_req, rx_expect_sync, rx_valid, tx_valid, tx_ready, acc_timeout, sig_read, pull_low;
	logic [7:0] s_axi_awaddr, s_axi_araddr, rx_data, tx_data, rx_got, d;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, link_clock_select, resp;
	int comparisons = 0, miscompares = 0, n_rx = 0, n_rst = 0, bl;
	// pull-up unless someone drives low
	wire logic line_in = !((line_oe && !line_out) || pull_low);
	odl_link_ctrl #(.STARTUP_TIMEOUT(STO), .GPIO_GUARD_CYCLES(GG)) odl_link_ctrl_i (.core_clk, .arst_n, .ce,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_in, .line_out, .line_oe, .pullup_en,
		.fuse_reset_pin_config, .hv_pulse, .clk_ready, .clk_req, .link_clock_select, .sys_reset_evt,
		.gpio_oe_allow, .sys_reset_req, .rx_expect_sync, .rx_valid, .rx_data, .tx_valid, .tx_data, .tx_ready,
		.acc_timeout, .sig_read);
	odl_debugger odl_debugger_i (.core_clk, .pull_low);
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		if (rx_valid === 1'b1)
			rx_got <= rx_data;
		if (rx_valid === 1'b1)
			n_rx <= n_rx + 1;
		if (sys_reset_req === 1'b1)
			n_rst <= n_rst + 1;
	end
	function automatic logic [31:0] ca(input logic [2:0] g, input logic [1:0] c);
		return {26'h0, c, 1'b0, g};
	endfunction
	function automatic logic [31:0] st(input logic [3:0] s, input logic [2:0] g);
		return {21'h0, g, 4'h0, s};
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
		logic aw, w, b;
		b = 1'b0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (b !== 1'b1)
		begin
			@(negedge core_clk);
			aw = s_axi_awready;
			w = s_axi_wready;
			b = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge core_clk);
			if (aw === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (w === 1'b1)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		logic ar, r;
		r = 1'b0;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (r !== 1'b1)
		begin
			@(negedge core_clk);
			ar = s_axi_arready;
			r = s_axi_rvalid;
			rd_d = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge core_clk);
			if (ar === 1'b1)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask
	task automatic done_test(input string nm);
		$display("test %s done", nm);
	endtask
	initial
	begin
		cyc(40000);
		miscompares++;
		complete_run();
	end
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, hv_pulse} = '0;
		{clk_ready, sys_reset_evt, rx_expect_sync, tx_valid, acc_timeout, sig_read, arst_n} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, tx_data} = '0;
		ce = 1'b1;
		fuse_reset_pin_config = FUSE_PIN_LINK;
		void'($urandom(32'hbfb2));
		bl = 8 + $urandom % 24;
		d = 8'($urandom);
		cyc(3);
		arst_n <= 1'b1;
		rd(ADDR_CTRL_A);
		chk("ctrl_a", rd_d, ca(GUARD_RESET, CLKSEL_DEFAULT));
		rd(ADDR_BAUD);
		chk("baud", rd_d, 32'(BIT_MAX));
		rd(8'h10);
		chk("rresp", resp, AXI_SLVERR);
		wr(8'h14, 32'h0, 4'hf);
		chk("bresp", resp, AXI_SLVERR);
		wr(ADDR_CTRL_A, 32'h0, 4'h0);
		rd(ADDR_CTRL_A);
		chk("ctrl_a", rd_d, ca(GUARD_RESET, CLKSEL_DEFAULT));
		chk("pullup", pullup_en, 1'b1);
		done_test("reset");
		odl_debugger_i.hold(1'b0, 30);
		@(negedge core_clk);
		chk("clk_req", {line_oe, clk_req}, 2'h3);
		odl_debugger_i.hold(1'b1, 5);
		chk("line", line_in, 1'b0);
		clk_ready <= 1'b1;
		cyc(4);
		@(negedge core_clk);
		chk("line", line_in, 1'b1);
		cyc(STO - 20);
		chk("clk_req", clk_req, 1'b1);
		cyc(30);
		chk("clk_req", clk_req, 1'b0);
		done_test("startup timeout");
		odl_debugger_i.hold(1'b0, 30);
		odl_debugger_i.hold(1'b1, 10);
		odl_debugger_i.frame(SYNC_CHAR, bl, 1'b0);
		rd(ADDR_STATUS);
		chk("status", rd_d & 32'h70f, st(4'h4, ERR_NONE));
		rd(ADDR_BAUD);
		chk("baud", rd_d, bl);
		odl_debugger_i.frame(d, bl, 1'b0);
		@(negedge core_clk);
		chk("rx_data", rx_got, d);
		chk("tx_ready", tx_ready, 1'b0);
		cyc(300);
		chk("tx_ready", {tx_ready, clk_req}, 2'h3);
		tx_data <= d;
		tx_valid <= 1'b1;
		cyc(1);
		tx_valid <= 1'b0;
		for (int i = 0; i < 10; i++)
		begin
			cyc(i == 0 ? bl / 2 : bl);
			rd_d[i] = line_in;
		end
		chk("tx frame", rd_d[9:0], {^d, d, 1'b0});
		cyc(3 * bl);
		done_test("sync and byte");
		odl_debugger_i.frame(d, bl, 1'b1);
		rd(ADDR_STATUS);
		chk("status", rd_d & 32'h70f, st(4'h7, ERR_PARITY));
		odl_debugger_i.frame(d, bl, 1'b0);
		chk("rx count", n_rx, 1);
		wr(ADDR_CTRL_A, ca(3'h2, 2'h0), 4'h1);
		chk("clksel", link_clock_select, 2'h0);
		odl_debugger_i.hold(1'b0, 26 * bl);
		odl_debugger_i.hold(1'b1, 4);
		rd(ADDR_CTRL_A);
		chk("ctrl_a", rd_d, ca(3'h2, CLKSEL_DEFAULT));
		rd(ADDR_STATUS);
		chk("status", rd_d & 32'h70f, st(4'h4, ERR_PARITY));
		rd(ADDR_BAUD);
		chk("baud", rd_d, 32'(BIT_MAX));
		odl_debugger_i.frame(SYNC_CHAR, bl, 1'b0);
		sig_read <= 1'b1;
		cyc(1);
		sig_read <= 1'b0;
		rd(ADDR_STATUS);
		chk("status", rd_d & 32'h70f, st(4'h4, ERR_NONE));
		done_test("error recovery");
		acc_timeout <= 1'b1;
		cyc(1);
		acc_timeout <= 1'b0;
		rd(ADDR_STATUS);
		chk("status", rd_d & 32'h70f, st(4'h7, ERR_ACCESS_TIMEOUT));
		wr(ADDR_CTRL_B, 32'h1, 4'hf);
		rd(ADDR_STATUS);
		chk("status", rd_d & 32'h70f, st(4'h0, ERR_NONE));
		chk("resets", {n_rst[7:0], clk_req, pullup_en}, {8'd1, 2'h1});
		rd(ADDR_CTRL_A);
		chk("ctrl_a", rd_d, ca(GUARD_RESET, CLKSEL_DEFAULT));
		done_test("disable");
		fuse_reset_pin_config <= 1'b0;
		arst_n <= 1'b0;
		cyc(3);
		arst_n <= 1'b1;
		repeat (2)
		begin
			cyc(GG / 2);
			chk("gpio", {pullup_en, gpio_oe_allow}, 2'h0);
			cyc(GG);
			chk("gpio", {pullup_en, gpio_oe_allow}, 2'h1);
			sys_reset_evt <= 1'b1;
			cyc(1);
			sys_reset_evt <= 1'b0;
		end
		done_test("gpio holdoff");
		hv_pulse <= 1'b1;
		cyc(1);
		hv_pulse <= 1'b0;
		cyc(2);
		chk("pins", {pullup_en, gpio_oe_allow, clk_req}, 3'h4);
		odl_debugger_i.hold(1'b0, 30);
		odl_debugger_i.hold(1'b1, 10);
		odl_debugger_i.frame(SYNC_CHAR, bl, 1'b0);
		odl_debugger_i.frame(~d, bl, 1'b0);
		@(negedge core_clk);
		chk("key", {n_rx[7:0], rx_got}, {8'd2, ~d});
		wr(ADDR_CTRL_B, 32'h1, 4'hf);
		chk("pins", {pullup_en, clk_req}, 2'h2);
		done_test("high voltage");
		odl_debugger_i.hold(1'b0, 30);
		odl_debugger_i.hold(1'b1, 10);
		odl_debugger_i.frame(SYNC_CHAR, 4, 1'b0);
		rd(ADDR_STATUS);
		chk("status", rd_d & 32'h70f, st(4'h0, ERR_NONE));
		chk("clk_req", clk_req, 1'b0);
		done_test("short sync");
		complete_run();
	end
endmodule
`default_nettype wire
